// File: hw/scs_sequencer.sv
// Successive-approximation conversion sequencer with link-clock event crossing
// Function
// - Normal-mode conversion cycle starts at acknowledge fall, tracks first
// - Track eight internal clocks, then open switch
// - Normal mode: convert only after result read
// - Automatic mode: periodic starts, interval from field
// - Adjust trial code until balanced, store result
// - Eight-bit straight binary result
// - First transition at half step, then full steps
// - Automatic mode tracks lowest and highest results
// - Result sits in bits 11 to 4
// - Result holds its default until first conversion completes, lowest and highest until first automatic one
`timescale 1ns/1ps
module scs_sequencer #(
    parameter int AUTO_BASE_TICKS = scs_pkg::AUTO_BASE_TICKS
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic link_clk_in,
    input wire logic ack_fall_in,
    input wire logic result_read_in,
    input wire logic [scs_pkg::SEL_W-1:0] cycle_sel_in,
    input wire logic comp_in,
    output logic [scs_pkg::CODE_W-1:0] dac_code_out,
    output logic half_lsb_out,
    output logic sample_on_out,
    output logic busy_out,
    output logic conv_done_out,
    output logic [15:0] result_word_out,
    output logic [scs_pkg::CODE_W-1:0] lowest_out,
    output logic [scs_pkg::CODE_W-1:0] highest_out
);
    localparam int CW = scs_pkg::CODE_W;
    localparam int AW = scs_pkg::AUTO_CNT_W;
    localparam logic [AW-1:0] BASE_CYC = AW'(AUTO_BASE_TICKS * scs_pkg::TICK_CYC);
    localparam logic [7:0] TICK_LAST = 8'(scs_pkg::TICK_CYC - 1);
    localparam logic [3:0] TRACK_LAST = 4'(scs_pkg::TRACK_TICKS - 1);

    // Reset release synchronisers, one per domain
    logic rst_meta, rst_n;
    logic lrst_meta, lrst_n;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end
    always_ff @(posedge link_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            lrst_meta <= 1'b0;
            lrst_n <= 1'b0;
        end else begin
            lrst_meta <= 1'b1;
            lrst_n <= lrst_meta;
        end
    end

    // Link side: each event flips a toggle, safe across unrelated clocks
    logic ack_tgl, read_tgl, next_ack_tgl, next_read_tgl;
    always_comb begin
        next_ack_tgl = ack_tgl ^ ack_fall_in;
        next_read_tgl = read_tgl ^ result_read_in;
    end
    always_ff @(posedge link_clk_in or negedge lrst_n) begin
        if (!lrst_n) begin
            ack_tgl <= 1'b0;
            read_tgl <= 1'b0;
        end else begin
            ack_tgl <= next_ack_tgl;
            read_tgl <= next_read_tgl;
        end
    end

    // Core side: two flops per toggle and comparator, third flop for edges
    logic [2:0] ack_sync, read_sync;
    logic [1:0] comp_sync;
    logic ack_evt, read_evt, comp_s;
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ack_sync <= 3'h0;
            read_sync <= 3'h0;
            comp_sync <= 2'h0;
        end else begin
            ack_sync <= {ack_sync[1:0], ack_tgl};
            read_sync <= {read_sync[1:0], read_tgl};
            comp_sync <= {comp_sync[0], comp_in};
        end
    end
    assign ack_evt = ack_sync[2] ^ ack_sync[1];
    assign read_evt = read_sync[2] ^ read_sync[1];
    assign comp_s = comp_sync[1];

    // Sequencer state
    scs_pkg::scs_state_t state, next_state;
    logic [7:0] cnt, next_cnt;
    logic [3:0] tick_n, next_tick_n;
    logic [2:0] bit_idx, next_bit_idx;
    logic [CW-1:0] code, next_code;
    logic [15:0] result, next_result;
    logic [CW-1:0] low, next_low, high, next_high;
    logic done, next_done, armed, next_armed;
    logic conv_auto, next_conv_auto, sample_on, next_sample_on;
    logic [AW-1:0] auto_cnt, next_auto_cnt;

    // Next-state logic of the whole conversion cycle
    always_comb begin
        logic tick;
        logic auto_on;
        logic auto_due;
        logic start;
        logic [AW-1:0] interval;
        logic [CW-1:0] trial;
        tick = (cnt == TICK_LAST);
        auto_on = (cycle_sel_in != 3'h0);
        interval = BASE_CYC << (cycle_sel_in - 3'h1);
        auto_due = auto_on && (auto_cnt >= interval - AW'(1));
        start = 1'b0;
        trial = code;
        next_state = state;
        next_cnt = cnt;
        next_tick_n = tick_n;
        next_bit_idx = bit_idx;
        next_code = code;
        next_result = result;
        next_low = low;
        next_high = high;
        next_done = 1'b0;
        next_armed = armed | read_evt;
        next_conv_auto = conv_auto;
        // Saturating interval counter, restarted on every start
        next_auto_cnt = (&auto_cnt) ? auto_cnt : auto_cnt + AW'(1);
        case (state)
            scs_pkg::SCS_IDLE: begin
                // Normal mode waits for acknowledge fall after a read
                start = auto_on ? auto_due : (ack_evt && armed);
                if (start) begin
                    next_state = scs_pkg::SCS_TRACK;
                    next_cnt = 8'h00;
                    next_tick_n = 4'h0;
                    next_conv_auto = auto_on;
                    next_auto_cnt = '0;
                    // A read landing now still counts for the next start
                    if (!auto_on) begin
                        next_armed = read_evt;
                    end
                end
            end
            scs_pkg::SCS_TRACK: begin
                next_cnt = tick ? 8'h00 : cnt + 8'h01;
                if (tick) begin
                    next_tick_n = tick_n + 4'h1;
                    if (tick_n == TRACK_LAST) begin
                        // Open the sampling switch, first trial is MSB
                        next_state = scs_pkg::SCS_CONVERT;
                        next_tick_n = 4'h0;
                        next_code = scs_pkg::TRIAL_MSB;
                        next_bit_idx = 3'(CW - 1);
                    end
                end
            end
            scs_pkg::SCS_CONVERT: begin
                next_cnt = tick ? 8'h00 : cnt + 8'h01;
                if (tick) begin
                    // Comparator low means input below trial: drop the bit
                    if (!comp_s) begin
                        trial[bit_idx] = 1'b0;
                    end
                    if (bit_idx == 3'h0) begin
                        // Commit only once every bit is decided
                        next_state = scs_pkg::SCS_IDLE;
                        next_code = trial;
                        next_result = 16'(trial) << scs_pkg::RES_LSB;
                        next_done = 1'b1;
                        if (conv_auto) begin
                            next_low = (trial < low) ? trial : low;
                            next_high = (trial > high) ? trial : high;
                        end
                    end else begin
                        trial[3'(bit_idx - 3'h1)] = 1'b1;
                        next_bit_idx = bit_idx - 3'h1;
                        next_code = trial;
                    end
                end
            end
            default: begin
                next_state = scs_pkg::SCS_IDLE;
            end
        endcase
        next_sample_on = (next_state == scs_pkg::SCS_TRACK);
    end

    // Sequencer registers; armed at reset since no result awaits reading
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state <= scs_pkg::SCS_IDLE;
            cnt <= 8'h00;
            tick_n <= 4'h0;
            bit_idx <= 3'h0;
            code <= 8'h00;
            result <= scs_pkg::RESULT_RESET;
            low <= scs_pkg::LOWEST_RESET;
            high <= scs_pkg::HIGHEST_RESET;
            done <= 1'b0;
            armed <= 1'b1;
            conv_auto <= 1'b0;
            sample_on <= 1'b0;
            auto_cnt <= '0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            tick_n <= next_tick_n;
            bit_idx <= next_bit_idx;
            code <= next_code;
            result <= next_result;
            low <= next_low;
            high <= next_high;
            done <= next_done;
            armed <= next_armed;
            conv_auto <= next_conv_auto;
            sample_on <= next_sample_on;
            auto_cnt <= next_auto_cnt;
        end
    end

    // Outputs; DAC carries the half-step offset whenever out of reset
    assign dac_code_out = code;
    assign half_lsb_out = rst_n;
    assign sample_on_out = sample_on;
    assign busy_out = (state != scs_pkg::SCS_IDLE);
    assign conv_done_out = done;
    assign result_word_out = result;
    assign lowest_out = low;
    assign highest_out = high;

    // Track window spans exactly eight internal ticks
    sequence s_track_window;
        sample_on_out throughout ##103 1'b1;
    endsequence
    sequence s_convert_window;
        busy_out throughout ##103 1'b1;
    endsequence
    a_track_length: assert property (@(posedge clk_in) disable iff (!rst_n)
        $rose(sample_on_out) |-> s_track_window ##1 !sample_on_out)
        else $error("track window length wrong");
    a_convert_length: assert property (@(posedge clk_in) disable iff (!rst_n)
        $fell(sample_on_out) |-> s_convert_window ##1 conv_done_out)
        else $error("conversion did not end after eight ticks");
    a_ack_start: assert property (@(posedge clk_in) disable iff (!rst_n)
        (state == scs_pkg::SCS_IDLE && cycle_sel_in == 3'h0 && ack_evt && armed)
        |=> $rose(sample_on_out))
        else $error("acknowledge fall did not start tracking");
    a_norm_gated: assert property (@(posedge clk_in) disable iff (!rst_n)
        ($rose(sample_on_out) && !conv_auto) |-> $past(armed))
        else $error("normal conversion started without a read");
    a_auto_start: assert property (@(posedge clk_in) disable iff (!rst_n)
        ($rose(sample_on_out) && conv_auto) |->
        ($past(auto_cnt) >= (BASE_CYC << ($past(cycle_sel_in) - 3'h1)) - AW'(1)))
        else $error("automatic start before the interval ran out");
    a_result_commit: assert property (@(posedge clk_in) disable iff (!rst_n)
        conv_done_out |-> (result_word_out[11:4] == dac_code_out))
        else $error("stored result differs from final trial");
    a_result_field: assert property (@(posedge clk_in) disable iff (!rst_n)
        (result_word_out[15:12] == 4'h0) && (result_word_out[3:0] == 4'h0))
        else $error("result outside bits 11 to 4");
    a_result_hold: assert property (@(posedge clk_in) disable iff (!rst_n)
        !conv_done_out |-> $stable(result_word_out))
        else $error("result changed without a completed conversion");
    a_extreme_order: assert property (@(posedge clk_in) disable iff (!rst_n)
        (conv_done_out && conv_auto) |->
        (lowest_out <= result_word_out[11:4]) && (highest_out >= result_word_out[11:4]))
        else $error("lowest or highest not updated");
    a_extreme_hold: assert property (@(posedge clk_in) disable iff (!rst_n)
        !(conv_done_out && conv_auto) |-> $stable(lowest_out) && $stable(highest_out))
        else $error("extremes changed outside automatic conversion");

    // Start gating and bit order, beyond the window lengths above

    // Once due in automatic mode, tracking starts on the next edge
    a_auto_due: assert property (@(posedge clk_in) disable iff (!rst_n)
        (state == scs_pkg::SCS_IDLE && cycle_sel_in != 3'h0 &&
        auto_cnt >= (BASE_CYC << (cycle_sel_in - 3'h1)) - AW'(1)) |=> $rose(sample_on_out))
        else $error("automatic start missed its interval");

    // Normal mode without a pending read must stay idle
    a_norm_refuse: assert property (@(posedge clk_in) disable iff (!rst_n)
        (state == scs_pkg::SCS_IDLE && cycle_sel_in == 3'h0 && !armed) |=> !busy_out)
        else $error("normal conversion started while not armed");

    // Conversion always opens with the MSB trial
    a_msb_first: assert property (@(posedge clk_in) disable iff (!rst_n)
        $fell(sample_on_out) |-> (dac_code_out == scs_pkg::TRIAL_MSB))
        else $error("first trial is not the MSB");

    // Trial code moves only on internal clock ticks
    a_code_steady: assert property (@(posedge clk_in) disable iff (!rst_n)
        (busy_out && !sample_on_out && cnt != TICK_LAST) |=> $stable(dac_code_out))
        else $error("trial code changed between ticks");

    // Idle code stays put, so the DAC is quiet between conversions
    a_idle_quiet: assert property (@(posedge clk_in) disable iff (!rst_n)
        (!busy_out && !conv_done_out) |-> $stable(dac_code_out))
        else $error("trial code moved while idle");
endmodule // scs_sequencer

// File: hw/scs_pkg.sv
// Shared constants of the conversion sequencer
package scs_pkg;
    // Result width and placement inside the 16-bit result word
    localparam int CODE_W = 8;
    localparam int RES_LSB = 4;
    localparam int RES_MSB = 11;
    localparam int SEL_W = 3;
    // Reset values of the result and extreme registers
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [7:0] LOWEST_RESET = 8'hff;
    localparam logic [7:0] HIGHEST_RESET = 8'h00;
    localparam logic [7:0] TRIAL_MSB = 8'h80;
    // Timing: system clock and internal converter clock
    localparam int CLK_NS = 4;
    localparam int TRACK_NS = 400;
    localparam int TRACK_MAX_NS = 530;
    localparam int TRACK_TICKS = 8;
    localparam int INT_CLK_NS = TRACK_NS / TRACK_TICKS;
    // Least time per internal tick, rounded up to whole cycles
    localparam int TICK_CYC = (INT_CLK_NS + CLK_NS - 1) / CLK_NS;
    localparam int TRACK_CYC = TICK_CYC * TRACK_TICKS;
    // Default base interval of automatic mode, in internal ticks
    localparam int AUTO_BASE_TICKS = 32;
    localparam int AUTO_CNT_W = 20;
    // Sequencer states
    typedef enum logic [1:0] {
        SCS_IDLE,
        SCS_TRACK,
        SCS_CONVERT
    } scs_state_t;
endpackage

// File: sim/scs_host_model.sv
// Link-side host model issuing acknowledge and result-read events
`timescale 1ns/1ps
module scs_host_model (
    input wire logic link_clk_in,
    output logic ack_fall_out,
    output logic result_read_out
);
    // Both event lines rest low between requests
    initial begin
        ack_fall_out = 1'b0;
        result_read_out = 1'b0;
    end
    // One link-cycle pulse, launched and dropped off the falling edge
    task automatic pulse(input bit rd);
        @(negedge link_clk_in);
        if (rd) begin
            result_read_out = 1'b1;
        end else begin
            ack_fall_out = 1'b1;
        end
        @(negedge link_clk_in);
        ack_fall_out = 1'b0;
        result_read_out = 1'b0;
    endtask
endmodule // scs_host_model

// File: sim/scs_sequencer_tb.sv
// Self-checking bench of the conversion sequencer
`timescale 1ns/1ps
module scs_sequencer_tb;
    localparam int BASE = 32;
    logic clk_in = 1'b0;
    logic link_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [2:0] cycle_sel = 3'h0;
    logic ack;
    logic rd;
    logic [7:0] dac;
    logic half;
    logic sample_on;
    logic busy;
    logic done;
    logic [15:0] word;
    logic [7:0] lo;
    logic [7:0] hi;
    int vin4 = 0;
    int cyc = 0;
    int error_cnt = 0;
    int checks_done = 0;
    // Comparator: input in quarter steps against trial level minus half-step offset
    wire comp = (vin4 > 4 * int'(dac) - 2 * int'(half));
    scs_sequencer #(.AUTO_BASE_TICKS(BASE)) dut_u (.clk_in(clk_in), .resetn_in(resetn_in),
        .link_clk_in(link_clk_in), .ack_fall_in(ack), .result_read_in(rd),
        .cycle_sel_in(cycle_sel), .comp_in(comp), .dac_code_out(dac), .half_lsb_out(half),
        .sample_on_out(sample_on), .busy_out(busy), .conv_done_out(done),
        .result_word_out(word), .lowest_out(lo), .highest_out(hi));
    scs_host_model host_u (.link_clk_in(link_clk_in), .ack_fall_out(ack),
        .result_read_out(rd));
    // Two unrelated clocks
    initial begin
        forever #2 clk_in = ~clk_in;
    end
    initial begin
        #1.3;
        forever #7.5 link_clk_in = ~link_clk_in;
    end
    // Hang guard: well above the expected run length
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Ideal code: first step at half a step, then one step apart
    function automatic logic [7:0] exp_code(input int v);
        int k;
        k = (v + 1) / 4;
        return (k > 255) ? 8'hff : 8'(k);
    endfunction
    // Waits for track start (0), track end (1) or done (2), bounded
    task automatic wait_for(input int what, output int n);
        for (n = 1; n < 3000; n++) begin
            @(negedge clk_in);
            if (what == 0 && sample_on === 1'b1) return;
            if (what == 1 && sample_on === 1'b0) return;
            if (what == 2 && done === 1'b1) return;
        end
        chk(16'h0, 16'hdead);
    endtask
    // One whole conversion, judged on timing, trial code and stored word
    task automatic conv_one(input int v, input bit auto_m, output int t0);
        int n;
        vin4 = v;
        if (!auto_m) host_u.pulse(1'b0);
        wait_for(0, n);
        t0 = cyc;
        if (!auto_m) chk(16'(n <= 8), 16'h1);
        chk(16'(busy), 16'h1);
        wait_for(1, n);
        chk(16'(n), 16'(scs_pkg::TRACK_CYC));
        chk(16'(n * 4 >= scs_pkg::TRACK_NS && n * 4 <= scs_pkg::TRACK_MAX_NS), 16'h1);
        chk(16'(dac), 16'(scs_pkg::TRIAL_MSB));
        wait_for(2, n);
        chk(16'(n), 16'(scs_pkg::TICK_CYC * scs_pkg::CODE_W));
        chk(word, {4'h0, exp_code(v), 4'h0});
        @(negedge clk_in);
        chk(16'(done), 16'h0);
    endtask
    task automatic t_reset();
        chk(word, scs_pkg::RESULT_RESET);
        chk({lo, hi}, {scs_pkg::LOWEST_RESET, scs_pkg::HIGHEST_RESET});
        chk(16'(half), 16'h1);
        chk(16'(busy), 16'h0);
    endtask
    // Boundary inputs around the first steps, mid-scale and full scale, read between each
    task automatic t_normal();
        int vins[5] = '{0, 1, 3, 514, 1021};
        int t0;
        foreach (vins[i]) begin
            conv_one(vins[i], 1'b0, t0);
            host_u.pulse(1'b1);
        end
        chk({lo, hi}, 16'hff00);
    endtask
    // Acknowledge without a read in between must not start a conversion
    task automatic t_refuse();
        int t0;
        conv_one(600, 1'b0, t0);
        host_u.pulse(1'b0);
        repeat (40) @(negedge clk_in);
        chk(16'(busy), 16'h0);
        host_u.pulse(1'b1);
        conv_one(2, 1'b0, t0);
    endtask
    // Periodic starts at two interval settings, extremes tracked
    task automatic t_auto();
        int t0;
        int t1;
        for (int sel = 1; sel <= 3; sel += 2) begin
            @(negedge clk_in);
            cycle_sel = 3'(sel);
            conv_one(sel * 100, 1'b1, t0);
            conv_one(sel * 300, 1'b1, t1);
            chk(16'(t1 - t0), 16'((BASE * scs_pkg::TICK_CYC) << (sel - 1)));
        end
        cycle_sel = 3'h0;
        chk({lo, hi}, {exp_code(100), exp_code(900)});
    endtask
    // Main sequence
    initial begin
        repeat (8) @(negedge clk_in);
        resetn_in = 1'b1;
        repeat (16) @(negedge clk_in);
        t_reset();
        t_normal();
        t_refuse();
        t_auto();
        conclude();
    end
endmodule // scs_sequencer_tb
